// ===== t2cm_timer.sv
// Third timer with control/mode registers behind an APB slave.
`timescale 1ns/1ps
`include "t2cm_map.svh"
// How it works
// (R01) Overflow sets flag, not in baud mode
// (R02) Trigger capture or reload sets external flag
// (R03) No external interrupt in up/down mode
// (R04) Receive baud from this timer or timer1
// (R05) Transmit baud from this timer or timer1
// (R06) Trigger edge reloads/captures unless baud or up/down mode
// (R07) Trigger ignored when external enable clear
// (R08) Run bit set starts counting
// (R09) Source zero counts divided system clock
// (R10) Source one counts count pin falls
// (R11) Capture on trigger fall when selected
// (R12) Reload on overflow, and trigger if enabled
// (R13) Baud mode forces reload, ignores capture
// (R14) Clock out enable drives count pin when source is zero
// (R15) Down enable makes up/down counter
// (R16) Reserved mode bits written zero, read zero
// (R17) Run clear holds the count unless a trigger reload loads it
// (R18) Up/down direction follows trigger pin level
module t2cm_timer (
  // APB slave.
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Board pins.
  input  wire t2cm_pkg::t2cm_pin_in_t pins,
  output logic                      count_pin_out,
  output logic                      count_pin_oe,
  // Serial port side.
  input  wire logic                 timer1_ovf,
  output t2cm_pkg::t2cm_baud_t      baud,
  output logic                      ext_irq,
  output logic                      ovf_irq
);
  import t2cm_pkg::*;

  t2cm_ctrl_t  ctrl;       // Control register.
  logic [7:0]  mode;       // Mode register, low two bits live.
  logic [15:0] count;      // Running count.
  logic [15:0] rld;        // Reload / capture register.
  logic [3:0]  div;        // Prescaler for timer operation.
  logic        clk_level;  // Clock-out toggle level.

  // Edge detectors on the two pins.
  logic trig_fall;
  logic cnt_fall;
  t2cm_edge u_trig (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (pins.trig),
    .fall    (trig_fall)
  );
  t2cm_edge u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (pins.count_in),
    .fall    (cnt_fall)
  );

  // Bus decode; the slave answers in the first access cycle.
  wire        acc     = psel & penable;
  wire        wr      = acc & pwrite;
  wire        hit_ctl = paddr == `T2CM_CTRL_OFF;
  wire        hit_mod = paddr == `T2CM_MODE_OFF;
  wire        hit_lo  = paddr == `T2CM_LOW_OFF;
  wire        hit_hi  = paddr == `T2CM_HIGH_OFF;
  wire        hit_rl  = paddr == `T2CM_RLD_LOW_OFF;
  wire        hit_rh  = paddr == `T2CM_RLD_HIGH_OFF;
  wire        mapped  = hit_ctl | hit_mod | hit_lo | hit_hi | hit_rl | hit_rh;
  wire        wr_ctl  = wr & hit_ctl;

  // Mode decode.
  wire baud_mode = ctrl.rx_sel | ctrl.tx_sel;
  wire down_count_enable      = mode[`T2CM_BIT_DOWN_COUNT_ENABLE];                       // (R15)
  wire clkout    = mode[`T2CM_BIT_CLKOE] & ~ctrl.csrc;         // (R14)
  // Trigger events only with enable and outside baud mode.
  wire ext_evt   = trig_fall & ctrl.exen & ~baud_mode;          // (R06) (R07)
  wire capture   = ext_evt & ctrl.capsel & ~down_count_enable;               // (R11) (R13)
  wire ext_rld   = ext_evt & ~ctrl.capsel & ~down_count_enable;              // (R12)

  // Prescaler: twelfth of system clock, or fast tick in baud/clock-out.
  wire [3:0] div_top = (baud_mode | clkout) ? `T2CM_DIV_BAUD
                                            : `T2CM_DIV_TIMER;
  wire div_tick = div >= div_top;
  wire tick     = ctrl.run & (ctrl.csrc ? cnt_fall : div_tick); // (R08) (R09) (R10) (R17)

  // Direction in up/down mode follows the trigger pin.
  wire down     = down_count_enable & ~pins.trig;                            // (R18)
  wire up_ovf   = tick & ~down & (count == 16'hFFFF);
  wire dn_ovf   = tick & down & (count == rld);
  wire ovf      = up_ovf | dn_ovf;
  // Reload on up overflow unless capture mode; baud and up/down modes force reload.
  wire ovf_rld  = up_ovf & (~ctrl.capsel | baud_mode | down_count_enable);   // (R12) (R13)

  logic [15:0] next_count;
  assign next_count = ovf_rld                ? rld :
                      dn_ovf                 ? 16'hFFFF :
                      ext_rld                ? rld :
                      (tick & down)          ? count - 16'h0001 :
                      tick                   ? count + 16'h0001 : count;

  // Prescaler counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 4'h0;
    end else if (div_tick) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  // Control register: flags set by hardware win over software clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `T2CM_CTRL_RESET;
    end else begin
      if (wr_ctl) begin
        ctrl <= pwdata[7:0];
      end
      if (ovf & ~baud_mode) begin
        ctrl.ovf <= 1'b1;                                      // (R01)
      end
      if (capture | ext_rld) begin
        ctrl.ext <= 1'b1;                                      // (R02)
      end
    end
  end

  // Mode register keeps only its two live bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `T2CM_MODE_RESET;
    end else if (wr & hit_mod) begin
      mode <= pwdata[7:0] & `T2CM_MODE_MASK;                   // (R16)
    end
  end

  // Count and reload/capture registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
      rld   <= 16'h0000;
    end else begin
      count <= next_count;
      if (wr & hit_lo) count[7:0] <= pwdata[7:0];
      if (wr & hit_hi) count[15:8] <= pwdata[7:0];
      if (capture) rld <= count;                               // (R11)
      else if (wr & hit_rl) rld[7:0] <= pwdata[7:0];
      else if (wr & hit_rh) rld[15:8] <= pwdata[7:0];
    end
  end

  // Read mux.
  logic [7:0] rd;
  assign rd = hit_ctl ? ctrl :
              hit_mod ? mode :
              hit_lo  ? count[7:0] :
              hit_hi  ? count[15:8] :
              hit_rl  ? rld[7:0] :
              hit_rh  ? rld[15:8] : 8'h00;

  // Registered APB answer, one cycle in access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= {24'h000000, rd};
    end
  end

  // Outputs: baud ticks, clock-out pin, interrupt requests.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud          <= '0;
      clk_level     <= 1'b0;
      count_pin_out <= 1'b0;
      count_pin_oe  <= 1'b0;
      ext_irq       <= 1'b0;
      ovf_irq       <= 1'b0;
    end else begin
      baud.rx_tick  <= ctrl.rx_sel ? ovf : timer1_ovf;          // (R04)
      baud.tx_tick  <= ctrl.tx_sel ? ovf : timer1_ovf;          // (R05)
      if (clkout & ovf) clk_level <= ~clk_level;
      count_pin_out <= clk_level;
      count_pin_oe  <= clkout;                                 // (R14)
      ext_irq       <= ctrl.ext & ~down_count_enable;                       // (R03)
      ovf_irq       <= ctrl.ovf;
    end
  end
endmodule

// ===== t2cm_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef T2CM_MAP_SVH
`define T2CM_MAP_SVH
`define T2CM_CTRL_OFF      12'h000
`define T2CM_MODE_OFF      12'h004
`define T2CM_LOW_OFF       12'h008
`define T2CM_HIGH_OFF      12'h00C
`define T2CM_RLD_LOW_OFF   12'h010
`define T2CM_RLD_HIGH_OFF  12'h014
`define T2CM_BAUD_OFF      12'h018
`define T2CM_BIT_OVF       7
`define T2CM_BIT_EXT       6
`define T2CM_BIT_RXSEL     5
`define T2CM_BIT_TXSEL     4
`define T2CM_BIT_EXEN      3
`define T2CM_BIT_RUN       2
`define T2CM_BIT_CSRC      1
`define T2CM_BIT_CAPSEL    0
`define T2CM_BIT_CLKOE     1
`define T2CM_BIT_DOWN_COUNT_ENABLE      0
`define T2CM_CTRL_RESET    8'h00
`define T2CM_MODE_RESET    8'h00
`define T2CM_MODE_MASK     8'h03
`define T2CM_DIV_TIMER     4'hB
`define T2CM_DIV_BAUD      4'h1
`endif

// ===== t2cm_pkg.sv
// Types shared by the timer block.
package t2cm_pkg;
  // Control register bits.
  typedef struct packed {
    logic ovf;
    logic ext;
    logic rx_sel;
    logic tx_sel;
    logic exen;
    logic run;
    logic csrc;
    logic capsel;
  } t2cm_ctrl_t;
  // Board-facing pins.
  typedef struct packed {
    logic trig;
    logic count_in;
  } t2cm_pin_in_t;
  // Serial port baud ticks.
  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
  } t2cm_baud_t;
endpackage

// ===== t2cm_edge.sv
// Falling edge detector for a pin taken as synchronous.
`timescale 1ns/1ps
module t2cm_edge (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin level and detected edge.
  input  wire logic pin,
  output logic      fall
);
  logic prev; // Pin level one cycle ago.

  // Remember the level; resets high so a pin already low out of reset gives a falling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b1;
    end else begin
      prev <= pin;
    end
  end

  assign fall = prev & ~pin;
endmodule

// ===== t2cm_timer_asserts.sv
// Port-level checks for the third timer block.
`timescale 1ns/1ps
module t2cm_timer_asserts (
  // APB side.
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  // Pin and serial side.
  input wire logic                 count_pin_oe,
  input wire logic                 timer1_ovf,
  input wire t2cm_pkg::t2cm_baud_t baud,
  input wire logic                 ext_irq,
  input wire logic                 ovf_irq
);
  import t2cm_pkg::*;
  logic [7:0] ctl; // Shadow of the control byte.
  logic [7:0] md;  // Shadow of the mode byte.
  wire        acc  = psel & penable & pready & pwrite;
  wire        clr  = acc && paddr == 12'h000 && !pwdata[7];
  wire        bsel = ctl[5] | ctl[4];
  // Shadows follow completed writes only, as the slave does.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h00;
      md <= 8'h00;
    end else if (acc && paddr == 12'h000) ctl <= pwdata[7:0];
    else if (acc && paddr == 12'h004) md <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_OVF_SET: assert property ($rose(ovf_irq) |-> !bsel && !$past(bsel))
    else $error("overflow flag set in baud mode");
  AST_OVF_CLR: assert property ($fell(ovf_irq) |-> $past(clr) || $past(clr, 2))
    else $error("overflow flag cleared without a write");
  AST_EXT_OFF: assert property ($rose(ext_irq) |-> ctl[3] || $past(ctl[3]))
    else $error("external flag with trigger disabled");
  AST_EXT_DOWN: assert property (md[0] && $past(md[0]) |-> !ext_irq)
    else $error("external request in up/down mode");
  AST_RX_T1: assert property (baud.rx_tick && !ctl[5] && !$past(ctl[5])
    |-> $past(timer1_ovf) || $past(timer1_ovf, 2))
    else $error("receive tick not from timer 1");
  AST_TX_T1: assert property (baud.tx_tick && !ctl[4] && !$past(ctl[4])
    |-> $past(timer1_ovf) || $past(timer1_ovf, 2))
    else $error("transmit tick not from timer 1");
  AST_OE_ON: assert property (md[1] && !ctl[1] && $past(md[1] && !ctl[1])
    |-> count_pin_oe)
    else $error("clock out not driven");
  AST_OE_OFF: assert property (!md[1] && !$past(md[1]) |-> !count_pin_oe)
    else $error("count pin driven while disabled");
  AST_RSV: assert property (psel && penable && pready && !pwrite
    && paddr == 12'h004 |-> prdata[31:2] == 30'h0)
    else $error("reserved mode bits not zero");
  cover property ($rose(ovf_irq));
  cover property (baud.rx_tick && ctl[5]);
  cover property ($rose(ext_irq));
endmodule
bind t2cm_timer t2cm_timer_asserts i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .count_pin_oe, .timer1_ovf,
  .baud, .ext_irq, .ovf_irq);

// ===== t2cm_board.sv
// Board model for the trigger pin, count pin and timer 1 overflow.
`timescale 1ns/1ps
module t2cm_board (
  // Clock and the block's clock-out drive.
  input  wire logic              pclk,
  input  wire logic              oe,
  input  wire logic              drv,
  // Levels seen by the block.
  output t2cm_pkg::t2cm_pin_in_t pins,
  output logic                   t1_ovf
);
  import t2cm_pkg::*;
  logic       trig = 1'b1; // Trigger idles high.
  logic       cnt  = 1'b1; // Count pin idles high.
  logic [3:0] div  = 4'h0; // Timer 1 stand-in divider.
  // The block's clock-out owns the shared pin while it drives it.
  assign pins = {trig, oe ? drv : cnt};
  assign t1_ovf = (div == 4'hF);
  always @(posedge pclk) div <= div + 4'h1;
  // Low for three cycles so the synchronous edge detector sees it.
  task automatic fall(input logic t);
    @(posedge pclk);
    if (t) trig <= 1'b0;
    else cnt <= 1'b0;
    repeat (3) @(posedge pclk);
    trig <= 1'b1;
    cnt <= 1'b1;
  endtask
endmodule

// ===== test_t2cm_timer.sv
// Self-checking bench for the third timer block.
`timescale 1ns/1ps
module test_t2cm_timer;
  import t2cm_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic         count_pin_out, count_pin_oe, timer1_ovf, ext_irq, ovf_irq;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  t2cm_pin_in_t pins;
  t2cm_baud_t   baud;
  int           err_count, cmp_count;
  t2cm_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pins, .count_pin_out,
    .count_pin_oe, .timer1_ovf, .baud, .ext_irq, .ovf_irq);
  t2cm_board i_board (.pclk, .oe(count_pin_oe), .drv(count_pin_out),
    .pins, .t1_ovf(timer1_ovf));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt();
    repeat (3) @(posedge pclk);
  endtask
  task automatic test_done();
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_regs();
    apb(0, 12'h000, 8'h00);
    chk(rd, 32'h0);
    apb(1, 12'hFFC, 8'hFF);
    chk(se, 32'h1);
    apb(1, 12'h004, 8'h02);
    wt();
    chk(count_pin_oe, 32'h1);
    chk(count_pin_out, 32'h0);
    apb(1, 12'h004, 8'hFF);
    apb(0, 12'h004, 8'h00);
    chk(rd, 32'h3);
    apb(1, 12'h004, 8'h00);
  endtask
  task automatic t_timer();
    logic [31:0] a;
    apb(1, 12'h008, 8'h00);
    apb(1, 12'h000, 8'h04);
    repeat (60) @(posedge pclk);
    apb(1, 12'h000, 8'h00);
    apb(0, 12'h008, 8'h00);
    a = rd;
    chk(a > 3 && a < 7, 32'h1);
    repeat (30) @(posedge pclk);
    apb(0, 12'h008, 8'h00);
    chk(rd, a);
  endtask
  // Three falls from FFFD overflow once and reload 1234.
  task automatic t_count();
    apb(1, 12'h010, 8'h34);
    apb(1, 12'h014, 8'h12);
    apb(1, 12'h008, 8'hFD);
    apb(1, 12'h00C, 8'hFF);
    apb(1, 12'h000, 8'h06);
    repeat (3) i_board.fall(1'b0);
    wt();
    chk(ovf_irq, 32'h1);
    apb(0, 12'h00C, 8'h00);
    chk(rd, 32'h12);
    apb(1, 12'h000, 8'h00);
    wt();
    chk(ovf_irq, 32'h0);
  endtask
  task automatic t_trig();
    apb(1, 12'h008, 8'h55);
    apb(1, 12'h000, 8'h03);
    i_board.fall(1'b1);
    apb(0, 12'h010, 8'h00);
    chk(rd, 32'h34);
    apb(1, 12'h000, 8'h0B);
    i_board.fall(1'b1);
    wt();
    chk(ext_irq, 32'h1);
    apb(0, 12'h010, 8'h00);
    chk(rd, 32'h55);
    apb(1, 12'h004, 8'h01);
    wt();
    chk(ext_irq, 32'h0);
    apb(1, 12'h004, 8'h00);
    apb(1, 12'h008, 8'h77);
    apb(1, 12'h000, 8'h0A);
    i_board.fall(1'b1);
    apb(0, 12'h008, 8'h00);
    chk(rd, 32'h55);
  endtask
  // Capture select is set on purpose: baud mode must still reload.
  task automatic t_baud();
    int n;
    apb(1, 12'h010, 8'hF0);
    apb(1, 12'h014, 8'hFF);
    apb(1, 12'h008, 8'hF0);
    apb(1, 12'h00C, 8'hFF);
    apb(1, 12'h000, 8'h35);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      n += (baud.rx_tick === 1'b1 && baud.tx_tick === 1'b1);
    end
    chk(n > 3, 32'h1);
    chk(ovf_irq, 32'h0);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_timer();
    t_count();
    t_trig();
    t_baud();
    test_done();
  end
  // Cuts a hang short well after the scenarios should have ended.
  initial begin
    #300000;
    err_count++;
    test_done();
  end
endmodule
